// [egp_map.svh]
// Purpose: address map, reset values and pin masks of the eight-pin port pair
// Assumes: three-bit byte index on the plain register port
// Notes:   definitions only, shared by the package users and the design
`ifndef EGP_MAP_SVH
`define EGP_MAP_SVH

// register indices on the plain port
`define EGP_ADDR_W           3
`define EGP_OFF_P6_DATA      3'h0
`define EGP_OFF_P6_DIR       3'h1
`define EGP_OFF_P6_PULL      3'h2
`define EGP_OFF_P7_DATA      3'h3
`define EGP_OFF_P7_DIR       3'h4
`define EGP_OFF_P7_PULL      3'h5
`define EGP_OFF_STBY_CTRL    3'h6

// reset values
`define EGP_DIR_RESET        8'h00
`define EGP_LATCH_RESET      8'h00
`define EGP_PULL_RESET       8'h00
`define EGP_ZERO_BYTE        8'h00
`define EGP_STBY_RESET       1'h0

// standby control field
`define EGP_SPL_BIT          0

// per-port pin masks
`define EGP_P6_OD_MASK       8'h00
`define EGP_P7_OD_MASK       8'h0c
`define EGP_P6_WAKE_MASK     8'h90
`define EGP_P7_WAKE_MASK     8'hb0

`endif

// [egp_pkg.sv]
// Purpose: shared types of the eight-pin port pair
// Assumes: eight pins per port
// Notes:   pin and peripheral groups travel as packed structs
`default_nettype none

package egp_pkg;

   // drive seen by one port's board pins
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull;
   } egp_pins_type;

   // on-chip peripheral outputs sharing one port
   typedef struct packed {
      logic [7:0] oe;
      logic [7:0] out;
   } egp_periph_type;

endpackage : egp_pkg

`default_nettype wire

// [egp_port_top.sv]
// Purpose: two eight-pin general-purpose ports with latch, direction, pull-up
// Assumes: one 25 MHz clock, synchronous active-high reset, clock enable
// Notes:   pin inputs are double-synchronised; all outputs are registered
`timescale 1ns/10ps
`default_nettype none
`include "egp_map.svh"

module egp_port
#(
   parameter logic [7:0] OD_MASK   = `EGP_ZERO_BYTE,
   parameter logic [7:0] WAKE_MASK = `EGP_ZERO_BYTE
)
(
   // clock, reset, enable
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   // register writes
   input  wire logic                  data_we,
   input  wire logic                  dir_we,
   input  wire logic                  pull_we,
   input  wire logic [7:0]            wdata,
   // standby and wake
   input  wire logic                  float_en,
   input  wire logic                  hold_en,
   input  wire logic [7:0]            wake_en,
   // peripheral outputs and pin level
   input  wire egp_pkg::egp_periph_type periph,
   input  wire logic [7:0]            pin_in,
   // state for readback
   output logic [7:0]                 latch_r,
   output logic [7:0]                 dir_r,
   output logic [7:0]                 pull_r,
   output logic [7:0]                 pin_level,
   // registered drive and peripheral inputs
   output egp_pkg::egp_pins_type      pins_r,
   output logic [7:0]                 periph_in_r
);
   import egp_pkg::*;

   logic [7:0]    sync1_r;
   logic [7:0]    sync2_r;
   logic [7:0]    drive;
   logic [7:0]    value;
   logic [7:0]    unblock;
   egp_pins_type  pins_nxt;

   // two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_r <= `EGP_ZERO_BYTE;
         sync2_r <= `EGP_ZERO_BYTE;
      end
      else if (ce)
      begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
      end
   end
   assign pin_level = sync2_r;

   // output latch, bit n maps to pin n
   // latch write
   always_ff @(posedge clk)
   begin
      if (rst)
         latch_r <= `EGP_LATCH_RESET;
      else if (ce && data_we)
         latch_r <= wdata;
   end

   // direction register
   // direction reset
   always_ff @(posedge clk)
   begin
      if (rst)
         dir_r <= `EGP_DIR_RESET;
      else if (ce && dir_we)
         dir_r <= wdata;
   end

   // pull-up register; open-drain pins have no pull-up, so those bits stay 0
   always_ff @(posedge clk)
   begin
      if (rst)
         pull_r <= `EGP_PULL_RESET;
      else if (ce && pull_we)
         pull_r <= wdata & ~OD_MASK;
   end

   // pin drive selection
   // drive sources
   assign drive = dir_r | periph.oe;
   assign value = (periph.oe & periph.out) | (~periph.oe & latch_r);

   always_comb
   begin
      pins_nxt = pins_r;
      if (float_en)
      begin
         pins_nxt.oe   = `EGP_ZERO_BYTE;
         pins_nxt.pull = pull_r;
      end
      else if (!hold_en)
      begin
         pins_nxt.out  = value & ~OD_MASK;
         pins_nxt.oe   = (drive & ~OD_MASK) | (drive & OD_MASK & ~value);
         pins_nxt.pull = pull_r & ~(pins_nxt.oe & ~pins_nxt.out);
      end
   end

   // pin drive register; standby without float freezes it
   // hold levels
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pins_r.out  <= `EGP_ZERO_BYTE;
         pins_r.oe   <= `EGP_ZERO_BYTE;
         pins_r.pull <= `EGP_ZERO_BYTE;
      end
      else if (ce)
         pins_r <= pins_nxt;
   end

   // input path to peripherals, clamped low in float except enabled wake pins, to stop leakage
   // input blocking
   assign unblock = ~{8{float_en}} | (wake_en & WAKE_MASK);
   always_ff @(posedge clk)
   begin
      if (rst)
         periph_in_r <= `EGP_ZERO_BYTE;
      else if (ce)
         periph_in_r <= sync2_r & unblock;
   end

   default clocking egp_cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_dir_reset: assert property (
      @(posedge clk) disable iff (1'b0) rst |=> dir_r == `EGP_DIR_RESET)
      else $error("direction not cleared by reset");
   a_latch_write: assert property (
      ce && data_we |=> latch_r == $past(wdata))
      else $error("latch missed a write");
   a_out_drive: assert property (
      ce && !float_en && !hold_en && !(|periph.oe) && !(|OD_MASK)
      |=> pins_r.oe == $past(dir_r) && pins_r.out == $past(latch_r))
      else $error("output pin not driving latch");
   a_in_undriven: assert property (
      ce && !float_en && !hold_en
      |=> (pins_r.oe & ~$past(drive)) == `EGP_ZERO_BYTE)
      else $error("input pin driven");
   a_float_hiz: assert property (
      ce && float_en |=> pins_r.oe == `EGP_ZERO_BYTE)
      else $error("pin driven in forced float");
   a_block_low: assert property (
      ce && float_en
      |=> (periph_in_r & ~$past(wake_en & WAKE_MASK)) == `EGP_ZERO_BYTE)
      else $error("blocked input not low");
   a_wake_pass: assert property (
      ce && float_en |=> (periph_in_r & $past(wake_en & WAKE_MASK))
      == ($past(sync2_r) & $past(wake_en & WAKE_MASK)))
      else $error("wake input blocked");
   a_hold_out: assert property (
      ce && hold_en && !float_en |=> $stable(pins_r))
      else $error("pins changed in hold standby");
   a_pull_low: assert property (
      (pins_r.pull & pins_r.oe & ~pins_r.out) == `EGP_ZERO_BYTE)
      else $error("pull-up on low-driven pin");
   a_od_release: assert property (
      (pins_r.out & OD_MASK) == `EGP_ZERO_BYTE)
      else $error("open-drain pin driven high");

   c_float_entry: cover property (ce && float_en ##1 pins_r.oe == 8'h00);
   c_periph_drive: cover property (ce && !float_en && |periph.oe);
   c_hold_standby: cover property (ce && hold_en ##1 ce && hold_en);

endmodule : egp_port

module egp_port_top
(
   // clock, reset, enable
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    ce,
   // register port
   input  wire logic [`EGP_ADDR_W-1:0]  addr,
   input  wire logic [7:0]              wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   input  wire logic                    rmw,
   output logic [7:0]                   rdata_r,
   // standby entry and wake controls
   input  wire logic                    stop_watch,
   input  wire logic [7:0]              p6_irq_chan_en,
   input  wire logic [7:0]              p6_irq_pin_sel,
   input  wire logic [7:0]              p7_irq_chan_en,
   input  wire logic [7:0]              p7_irq_pin_sel,
   // peripheral outputs
   input  wire egp_pkg::egp_periph_type p6_periph,
   input  wire egp_pkg::egp_periph_type p7_periph,
   // board pins
   input  wire logic [7:0]              p6_pin_in,
   input  wire logic [7:0]              p7_pin_in,
   output egp_pkg::egp_pins_type        p6_pins_r,
   output egp_pkg::egp_pins_type        p7_pins_r,
   // inputs to peripherals
   output logic [7:0]                   p6_periph_in_r,
   output logic [7:0]                   p7_periph_in_r
);
   import egp_pkg::*;

   logic       standby_pin_float_select_r;
   logic       float_en;
   logic       hold_en;
   logic [7:0] p6_latch, p6_dir, p6_pull, p6_level;
   logic [7:0] p7_latch, p7_dir, p7_pull, p7_level;
   logic [7:0] rdata_nxt;

   // standby control register, only the float select bit is held
   always_ff @(posedge clk)
   begin
      if (rst)
         standby_pin_float_select_r <= `EGP_STBY_RESET;
      else if (ce && wr && addr == `EGP_OFF_STBY_CTRL)
         standby_pin_float_select_r <= wdata[`EGP_SPL_BIT];
   end

   assign float_en = stop_watch & standby_pin_float_select_r;
   assign hold_en  = stop_watch & ~standby_pin_float_select_r;

   // port six; timer clock and trigger pins may stay awake
   egp_port
   #(
      .OD_MASK   (`EGP_P6_OD_MASK),
      .WAKE_MASK (`EGP_P6_WAKE_MASK)
   )
   u_port_six
   (
      .clk         (clk),
      .rst         (rst),
      .ce          (ce),
      .data_we     (wr && addr == `EGP_OFF_P6_DATA),
      .dir_we      (wr && addr == `EGP_OFF_P6_DIR),
      .pull_we     (wr && addr == `EGP_OFF_P6_PULL),
      .wdata       (wdata),
      .float_en    (float_en),
      .hold_en     (hold_en),
      .wake_en     (p6_irq_chan_en & p6_irq_pin_sel),
      .periph      (p6_periph),
      .pin_in      (p6_pin_in),
      .latch_r     (p6_latch),
      .dir_r       (p6_dir),
      .pull_r      (p6_pull),
      .pin_level   (p6_level),
      .pins_r      (p6_pins_r),
      .periph_in_r (p6_periph_in_r)
   );

   // port seven; bits two and three are open-drain
   egp_port
   #(
      .OD_MASK   (`EGP_P7_OD_MASK),
      .WAKE_MASK (`EGP_P7_WAKE_MASK)
   )
   u_port_seven
   (
      .clk         (clk),
      .rst         (rst),
      .ce          (ce),
      .data_we     (wr && addr == `EGP_OFF_P7_DATA),
      .dir_we      (wr && addr == `EGP_OFF_P7_DIR),
      .pull_we     (wr && addr == `EGP_OFF_P7_PULL),
      .wdata       (wdata),
      .float_en    (float_en),
      .hold_en     (hold_en),
      .wake_en     (p7_irq_chan_en & p7_irq_pin_sel),
      .periph      (p7_periph),
      .pin_in      (p7_pin_in),
      .latch_r     (p7_latch),
      .dir_r       (p7_dir),
      .pull_r      (p7_pull),
      .pin_level   (p7_level),
      .pins_r      (p7_pins_r),
      .periph_in_r (p7_periph_in_r)
   );

   // data read: latch for port outputs and RMW, else synced pin level
   // read source
   function automatic logic [7:0] data_view
   (
      input logic [7:0] latch,
      input logic [7:0] dir,
      input logic [7:0] poe,
      input logic [7:0] level,
      input logic       is_rmw
   );
      logic [7:0] use_latch;
      use_latch = {8{is_rmw}} | (dir & ~poe);
      return (use_latch & latch) | (~use_latch & level);
   endfunction : data_view

   // read mux; unmapped index reads zero
   always_comb
   begin
      rdata_nxt = `EGP_ZERO_BYTE;
      case (addr)
         `EGP_OFF_P6_DATA:
            rdata_nxt = data_view(p6_latch, p6_dir, p6_periph.oe,
                                  p6_level, rmw);
         `EGP_OFF_P6_DIR:  rdata_nxt = p6_dir;
         `EGP_OFF_P6_PULL: rdata_nxt = p6_pull;
         `EGP_OFF_P7_DATA:
            rdata_nxt = data_view(p7_latch, p7_dir, p7_periph.oe,
                                  p7_level, rmw);
         `EGP_OFF_P7_DIR:  rdata_nxt = p7_dir;
         `EGP_OFF_P7_PULL: rdata_nxt = p7_pull;
         `EGP_OFF_STBY_CTRL:
            rdata_nxt = {7'h00, standby_pin_float_select_r};
         default:          rdata_nxt = `EGP_ZERO_BYTE;
      endcase
   end

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         rdata_r <= `EGP_ZERO_BYTE;
      else if (ce)
         rdata_r <= rd ? rdata_nxt : `EGP_ZERO_BYTE;
   end

   default clocking egp_top_cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_rmw_latch: assert property (
      ce && rd && rmw && addr == `EGP_OFF_P6_DATA
      |=> rdata_r == $past(p6_latch))
      else $error("rmw read did not return latch");
   a_out_read: assert property (
      ce && rd && !rmw && addr == `EGP_OFF_P7_DATA && p7_dir == 8'hff
      && p7_periph.oe == 8'h00 |=> rdata_r == $past(p7_latch))
      else $error("output port read not latch");
   a_in_read: assert property (
      ce && rd && !rmw && addr == `EGP_OFF_P6_DATA && p6_dir == 8'h00
      |=> rdata_r == $past(p6_level))
      else $error("input read not pin level");

   c_rmw_read: cover property (ce && rd && rmw);
   c_float_mode: cover property (ce && float_en);

endmodule : egp_port_top

`default_nettype wire

// [egp_board_model.sv]
// Purpose: board-side model of the pins of both ports
// Assumes: chip drive wins over any board driver on the same pin
// Notes:   an undriven pin with no pull-up shows a changing pattern
`timescale 1ns/10ps
`default_nettype none

module egp_board_model
(
   // clock
   input  wire logic                  clk,
   // chip drive
   input  wire egp_pkg::egp_pins_type p6_pins,
   input  wire egp_pkg::egp_pins_type p7_pins,
   // board drivers
   input  wire logic [7:0]            p6_ext_en,
   input  wire logic [7:0]            p6_ext_val,
   input  wire logic [7:0]            p7_ext_en,
   input  wire logic [7:0]            p7_ext_val,
   // resolved pin levels
   output logic [7:0]                 p6_level,
   output logic [7:0]                 p7_level
);
   import egp_pkg::*;

   logic [7:0] flt_r = 8'h55;

   // floating pins flip each cycle so a stale value never reads back
   always @(posedge clk)
      flt_r <= ~flt_r;

   // chip first, then board, then pull-up, then float
   function automatic logic [7:0] resolve(input egp_pins_type p,
      input logic [7:0] en, input logic [7:0] val);
      resolve = (p.oe & p.out) | (~p.oe & en & val)
              | (~p.oe & ~en & (p.pull | flt_r));
   endfunction : resolve

   assign p6_level = resolve(p6_pins, p6_ext_en, p6_ext_val);
   assign p7_level = resolve(p7_pins, p7_ext_en, p7_ext_val);

endmodule : egp_board_model
`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench for the eight-pin port pair
// Assumes: ce held high except in the enable test; board model resolves the pin levels
// Notes:   reads are queued by the driver and checked by a monitor
`timescale 1ns/10ps
`default_nettype none
`include "egp_map.svh"

module testbench;
   import egp_pkg::*;

   logic           clk = 1'b0;
   logic           rst = 1'b1;
   logic           ce = 1'b1;
   logic [2:0]     addr = 3'h0;
   logic [7:0]     wdata = 8'h00;
   logic           wr = 1'b0;
   logic           rd = 1'b0;
   logic           rmw = 1'b0;
   logic           stop_watch = 1'b0;
   logic [7:0]     ce6 = 8'h00, ps6 = 8'h00, ce7 = 8'h00, ps7 = 8'h00;
   egp_periph_type p6_periph = '0, p7_periph = '0;
   logic [7:0]     e6_en = 8'h00, e6_val = 8'h00;
   logic [7:0]     e7_en = 8'h00, e7_val = 8'h00;
   logic [7:0]     rdata_r, lvl6, lvl7, pin6, pin7, d, v, w, m;
   egp_pins_type   p6_pins_r, p7_pins_r;
   logic [7:0]     exp_q[$];
   logic           rd_seen = 1'b0;
   int             bad_count = 0, num_checks = 0, cycles = 0;

   always #20 clk = ~clk;

   egp_port_top egp_port_top_inst
   (
      .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rmw(rmw), .rdata_r(rdata_r),
      .stop_watch(stop_watch),
      .p6_irq_chan_en(ce6), .p6_irq_pin_sel(ps6),
      .p7_irq_chan_en(ce7), .p7_irq_pin_sel(ps7),
      .p6_periph(p6_periph), .p7_periph(p7_periph),
      .p6_pin_in(lvl6), .p7_pin_in(lvl7),
      .p6_pins_r(p6_pins_r), .p7_pins_r(p7_pins_r),
      .p6_periph_in_r(pin6), .p7_periph_in_r(pin7)
   );

   egp_board_model egp_board_model_inst
   (
      .clk(clk), .p6_pins(p6_pins_r), .p7_pins(p7_pins_r),
      .p6_ext_en(e6_en), .p6_ext_val(e6_val),
      .p7_ext_en(e7_en), .p7_ext_val(e7_val),
      .p6_level(lvl6), .p7_level(lvl7)
   );

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [7:0] got, input logic [7:0] exp,
      input string what);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] dat);
      @(posedge clk);
      addr <= a;
      wdata <= dat;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // expectation goes on the queue in the strobe cycle
   task automatic rd_reg(input logic [2:0] a, input logic r,
      input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rmw <= r;
      rd <= 1'b1;
      exp_q.push_back(exp);
      @(posedge clk);
      rd <= 1'b0;
      rmw <= 1'b0;
   endtask : rd_reg

   // pins follow one edge after registers, levels two edges after pins
   task automatic settle();
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done

   // read data stands only in the cycle after the strobe, else zero
   always @(posedge clk)
      rd_seen <= rd & ~rst;
   always @(negedge clk)
      if (rd_seen)
         check(rdata_r, exp_q.pop_front(), "read data");
      else
         check(rdata_r, 8'h00, "idle read data");

   // hang guard, far above the roughly two hundred cycles needed
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         bad_count++;
         $display("BAD %0t timeout", $time);
         report_and_stop();
      end
   end

   initial
   begin
      void'($urandom(32'hd8e3057e));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++)
         rd_reg(3'(i), (i == 0 || i == 3), 8'h00);
      check(p6_pins_r.oe | p7_pins_r.oe, 8'h00, "reset oe");
      done("reset");
      // readback, with open-drain pull bits and unmapped index at zero
      for (int i = 1; i < 8; i++)
      begin
         d = $urandom;
         m = (i == 5) ? 8'hf3 : (i == 6) ? 8'h01 : (i == 7) ? 8'h00 : 8'hff;
         if (i != 3)
         begin
            wr_reg(3'(i), d);
            rd_reg(3'(i), 1'b0, d & m);
         end
      end
      wr_reg(`EGP_OFF_STBY_CTRL, 8'h00);
      done("readback");
      for (int k = 0; k < 8; k++)
      begin
         wr_reg(`EGP_OFF_P6_DIR, 8'h01 << k);
         settle();
         check(p6_pins_r.oe, 8'h01 << k, "dir walk");
      end
      d = $urandom;
      wr_reg(`EGP_OFF_P6_DIR, 8'hff);
      wr_reg(`EGP_OFF_P6_PULL, 8'hff);
      wr_reg(`EGP_OFF_P6_DATA, d);
      settle();
      check(p6_pins_r.out, d, "out value");
      check(p6_pins_r.pull, d, "pull off low");
      rd_reg(`EGP_OFF_P6_DATA, 1'b0, d);
      done("output");
      // input mode: latch written, pin not driven
      v = $urandom;
      w = $urandom;
      wr_reg(`EGP_OFF_P6_DIR, 8'h00);
      e6_en <= 8'hff;
      e6_val <= v;
      wr_reg(`EGP_OFF_P6_DATA, w);
      settle();
      check(p6_pins_r.oe, 8'h00, "input oe");
      check(p6_pins_r.pull, 8'hff, "pull on");
      check(pin6, v, "periph input");
      rd_reg(`EGP_OFF_P6_DATA, 1'b0, v);
      rd_reg(`EGP_OFF_P6_DATA, 1'b1, w);
      done("input");
      // peripheral drives the upper four pins with direction cleared
      @(posedge clk);
      p6_periph <= {8'hf0, d};
      settle();
      check(p6_pins_r.oe, 8'hf0, "periph oe");
      check(p6_pins_r.out & 8'hf0, d & 8'hf0, "periph out");
      check(p6_pins_r.pull, ~(8'hf0 & ~d), "periph pull");
      rd_reg(`EGP_OFF_P6_DATA, 1'b0, (d & 8'hf0) | (v & 8'h0f));
      rd_reg(`EGP_OFF_P6_DATA, 1'b1, w);
      @(posedge clk);
      p6_periph <= '0;
      done("peripheral");
      wr_reg(`EGP_OFF_P7_DIR, 8'hff);
      wr_reg(`EGP_OFF_P7_DATA, 8'hff);
      settle();
      check(p7_pins_r.oe, 8'hf3, "od release");
      wr_reg(`EGP_OFF_P7_DATA, 8'h00);
      settle();
      check(p7_pins_r.oe, 8'hff, "od low");
      rd_reg(`EGP_OFF_P7_DATA, 1'b0, 8'h00);
      done("open drain");
      wr_reg(`EGP_OFF_STBY_CTRL, 8'h01);
      wr_reg(`EGP_OFF_P6_DIR, 8'hff);
      for (int j = 0; j < 2; j++)
      begin
         @(posedge clk);
         {ce6, ps6, ce7, ps7} <= (j == 0) ? 32'hffffffff : $urandom;
         e7_en <= 8'hff;
         e7_val <= ~v;
         stop_watch <= 1'b1;
         settle();
         check(p6_pins_r.oe | p7_pins_r.oe, 8'h00, "float oe");
         m = ce6 & ps6 & `EGP_P6_WAKE_MASK;
         check(pin6, v & m, "wake six");
         m = ce7 & ps7 & `EGP_P7_WAKE_MASK;
         check(pin7, ~v & m, "wake seven");
         @(posedge clk);
         stop_watch <= 1'b0;
         settle();
         check(p6_pins_r.oe, 8'hff, "float exit");
      end
      done("float");
      wr_reg(`EGP_OFF_STBY_CTRL, 8'h00);
      stop_watch <= 1'b1;
      wr_reg(`EGP_OFF_P6_DATA, ~d);
      settle();
      check(p6_pins_r.out, w, "hold out");
      check(p6_pins_r.oe, 8'hff, "hold oe");
      @(posedge clk);
      stop_watch <= 1'b0;
      settle();
      check(p6_pins_r.out, ~d, "hold exit");
      done("hold");
      // clock enable low must freeze the latch against a write
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(`EGP_OFF_P6_DATA, d);
      ce <= 1'b1;
      rd_reg(`EGP_OFF_P6_DATA, 1'b0, ~d);
      done("enable");
      repeat (3) @(posedge clk);
      report_and_stop();
   end

endmodule : testbench
`default_nettype wire
